// ---- rtl/rlc_pkg.sv ----
/*
 rlc_pkg: constants, descriptor layout, register map, states and helpers
 for the receive look-ahead descriptor chain engine.
 assumes descriptors are 32-bit words addressed by ring index.
*/
package rlc_pkg;
   // ************************************************
   // descriptor word layout
   // ************************************************
   localparam int IDX_W = 8;
   localparam int CNT_W = 12;
   localparam int HOLD_BIT = 31;
   localparam int START_BIT = 30;
   localparam int END_BIT = 29;
   localparam int ERR_BIT = 28;
   localparam int BUFF_BIT = 27;
   localparam int CNT_LSB = 12;
   localparam int SIZE_LSB = 0;
   localparam logic [31:0] STAT_MASK = 32'h7fff_f000;
   localparam logic [31:0] HOLD_MASK = 32'h8000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
   // ************************************************
   // register map and events
   // ************************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_RING = 8'h04;
   localparam logic [7:0] REG_STAT = 8'h08;
   localparam logic [7:0] REG_IEN = 8'h0c;
   localparam logic [7:0] REG_ICLR = 8'h10;
   localparam logic [7:0] REG_CUR = 8'h14;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_LAH_BIT = 1;
   localparam logic [1:0] CTRL_RST = 2'h0;
   localparam logic [IDX_W-1:0] RING_RST = 8'h03;
   localparam int EV_W = 4;
   localparam int EV_DONE = 0;
   localparam int EV_ERR = 1;
   localparam int EV_BUFF = 2;
   localparam int EV_REL = 3;
   // ************************************************
   // types and helpers
   // ************************************************
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_FETCH = 3'h1, ST_FILL = 3'h3, ST_LOOK = 3'h2,
      ST_WSTAT = 3'h6, ST_WOWN = 3'h7, ST_DRAIN = 3'h5
   } rlc_state_type;
   typedef enum logic [1:0] {POST_ADV = 2'h0, POST_CHAIN = 2'h1, POST_DRAIN = 2'h2}
      rlc_post_type;
   function automatic logic [IDX_W-1:0] next_idx(input logic [IDX_W-1:0] idx,
                                                 input logic [IDX_W-1:0] len);
      logic [IDX_W-1:0] inc;
      inc = idx + 8'h01;
      next_idx = (inc >= len) ? 8'h00 : inc;
   endfunction
   function automatic logic [31:0] stat_word(input logic st, input logic en,
                                             input logic er, input logic bf,
                                             input logic [CNT_W-1:0] cnt);
      stat_word = 32'h0000_0000;
      stat_word[START_BIT] = st;
      stat_word[END_BIT] = en;
      stat_word[ERR_BIT] = er;
      stat_word[BUFF_BIT] = bf;
      stat_word[CNT_LSB +: CNT_W] = cnt;
   endfunction
endpackage

// ---- rtl/rlc_ifs.sv ----
/*
 rlc_desc_if: engine to descriptor access port; rlc_reg_if: engine to
 register file. assumes a single clock shared by all parties.
*/
`timescale 1ns/100ps
interface rlc_desc_if;
   logic req;
   logic we;
   logic [7:0] idx;
   logic [31:0] wdata;
   logic [31:0] wmask;
   logic [31:0] rdata;
   logic done;
   modport eng(output req, we, idx, wdata, wmask, input rdata, done);
   modport port(input req, we, idx, wdata, wmask, output rdata, done);
endinterface

interface rlc_reg_if;
   logic en;
   logic lah;
   logic [7:0] ring_len;
   logic [3:0] ev;
   logic [7:0] cur_idx;
   logic [2:0] state;
   modport eng(input en, lah, ring_len, output ev, cur_idx, state);
   modport regs(output en, lah, ring_len, input ev, cur_idx, state);
endinterface

// ---- rtl/rlc_desc_port.sv ----
/*
 rlc_desc_port: runs one descriptor read or masked write on the memory port.
 assumes memory holds mem_ack_in low until it has served a held request.
*/
`timescale 1ns/100ps
module rlc_desc_port
   import rlc_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   rlc_desc_if.port dp,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [IDX_W-1:0] mem_idx_out,
   output logic [31:0] mem_wdata_out,
   output logic [31:0] mem_wmask_out,
   input wire logic mem_ack_in,
   input wire logic [31:0] mem_rdata_in
);
   logic done_q;
   logic [31:0] rdata_q;

   assign dp.done = done_q;
   assign dp.rdata = rdata_q;

   // ************************************************
   // request launch and completion
   // ************************************************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_idx_out <= '0;
         mem_wdata_out <= '0;
         mem_wmask_out <= '0;
      end else if (!mem_req_out && dp.req && !done_q) begin
         mem_req_out <= 1'b1;
         mem_we_out <= dp.we;
         mem_idx_out <= dp.idx;
         mem_wdata_out <= dp.wdata;
         mem_wmask_out <= dp.wmask;
      end else if (mem_req_out && mem_ack_in) begin
         mem_req_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         done_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         done_q <= mem_req_out && mem_ack_in;
         if (mem_req_out && mem_ack_in) begin
            rdata_q <= mem_rdata_in;
         end
      end
   end
endmodule

// ---- rtl/rlc_irq_regs.sv ----
/*
 rlc_irq_regs: control, ring length, sticky event status, enable, clear
 and position registers with one level interrupt.
 assumes one-cycle strobes, read data wanted in the following cycle.
*/
`timescale 1ns/100ps
module rlc_irq_regs
   import rlc_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   rlc_reg_if.regs rg,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic irq_out
);
   logic [1:0] ctrl_q;
   logic [IDX_W-1:0] ring_q;
   logic [EV_W-1:0] stat_q;
   logic [EV_W-1:0] ien_q;
   logic [EV_W-1:0] clr;

   assign rg.en = ctrl_q[CTRL_EN_BIT];
   assign rg.lah = ctrl_q[CTRL_LAH_BIT];
   assign rg.ring_len = ring_q;
   assign clr = (reg_wr_in && reg_addr_in == REG_ICLR) ? reg_wdata_in[EV_W-1:0] : '0;

   // ************
   // writable registers
   // ************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         ctrl_q <= CTRL_RST;
         ring_q <= RING_RST;
         ien_q <= '0;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            REG_CTRL: ctrl_q <= reg_wdata_in[1:0];
            REG_RING: ring_q <= reg_wdata_in[IDX_W-1:0];
            REG_IEN: ien_q <= reg_wdata_in[EV_W-1:0];
            default: ;
         endcase
      end
   end

   // ************
   // sticky status, set wins over clear
   // ************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         stat_q <= '0;
         irq_out <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~clr) | rg.ev;
         irq_out <= |(stat_q & ien_q);
      end
   end

   // ************
   // read port
   // ************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         reg_rdata_out <= '0;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            REG_CTRL: reg_rdata_out <= {30'h0000_0000, ctrl_q};
            REG_RING: reg_rdata_out <= {24'h00_0000, ring_q};
            REG_STAT: reg_rdata_out <= {28'h000_0000, stat_q};
            REG_IEN: reg_rdata_out <= {28'h000_0000, ien_q};
            REG_CUR: reg_rdata_out <= {13'h0000, rg.state, 8'h00, rg.cur_idx};
            default: reg_rdata_out <= '0;
         endcase
      end else begin
         reg_rdata_out <= '0;
      end
   end
endmodule

// ---- rtl/rlc_rx_lookahead.sv ----
/*
 rlc_rx_lookahead: receive descriptor chain engine for early header
 processing. places each frame over ring descriptors, updates holder,
 start, end and error flags, and searches for the next frame start.
 assumes descriptor memory and the frame source run on clk_in.
*/
// Added by the designer: the address-and-strobe port and the address map.
`timescale 1ns/100ps
// Behaviour
// RL1: second buffer full, third granted: clear end, holder, start, continue in third.
// RL2: frame ends in second buffer before third granted: close second, skip third.
// RL3: never write end flag of a skipped, unheld descriptor.
// RL4: software ignores end flags after frame end until next start flag.
// RL5: frame fits first buffer: end there, release held second with end zero.
// RL6: after frame end poll onward; unheld descriptors stay unmodified.
// RL7: software changes buffer size only while software holds the descriptor.
// RL8: software readjusts second and third sizes whenever first size changes.
// RL9: self-tuning software keeps sizes on frames below a size threshold.
// RL10: new frame starts only in descriptor with holder and start set.
// RL11: searching, release held descriptor lacking start by clearing holder, advance.
// RL12: searching, skip unheld descriptors without modifying them.
// RL13: always close frame with end or error flag in last descriptor.
// RL14: write status fields before clearing a descriptor's holder flag.
module rlc_rx_lookahead
   import rlc_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic irq_out,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_last_in,
   input wire logic rx_err_in,
   output logic rx_ready_out,
   output logic dma_we_out,
   output logic [IDX_W-1:0] dma_idx_out,
   output logic [CNT_W-1:0] dma_off_out,
   output logic [7:0] dma_data_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [IDX_W-1:0] mem_idx_out,
   output logic [31:0] mem_wdata_out,
   output logic [31:0] mem_wmask_out,
   input wire logic mem_ack_in,
   input wire logic [31:0] mem_rdata_in
);
   // ************
   // declarations
   // ************
   rlc_desc_if dif();
   rlc_reg_if rif();

   rlc_state_type state_q;
   rlc_state_type state_d;
   rlc_post_type post_q;
   rlc_post_type post_d;
   logic [IDX_W-1:0] idx_q;
   logic [IDX_W-1:0] idx_d;
   logic [CNT_W-1:0] size_q;
   logic [CNT_W-1:0] size_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] nsize_q;
   logic [CNT_W-1:0] nsize_d;
   logic first_q;
   logic first_d;
   logic [31:0] wval_q;
   logic [31:0] wval_d;
   logic [EV_W-1:0] ev_q;
   logic [EV_W-1:0] ev_d;
   logic accept;
   logic d_hold;
   logic d_start;
   logic [CNT_W-1:0] cnt_inc;

   // ************
   // submodules
   // ************
   rlc_desc_port u_port (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .dp(dif.port),
      .mem_req_out(mem_req_out),
      .mem_we_out(mem_we_out),
      .mem_idx_out(mem_idx_out),
      .mem_wdata_out(mem_wdata_out),
      .mem_wmask_out(mem_wmask_out),
      .mem_ack_in(mem_ack_in),
      .mem_rdata_in(mem_rdata_in)
   );

   rlc_irq_regs u_regs (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .rg(rif.regs),
      .reg_addr_in(reg_addr_in),
      .reg_wdata_in(reg_wdata_in),
      .reg_wr_in(reg_wr_in),
      .reg_rd_in(reg_rd_in),
      .reg_rdata_out(reg_rdata_out),
      .irq_out(irq_out)
   );

   // ************
   // descriptor access requests
   // ************
   assign dif.req = (state_q == ST_FETCH) || (state_q == ST_LOOK) ||
                    (state_q == ST_WSTAT) || (state_q == ST_WOWN);
   assign dif.we = (state_q == ST_WSTAT) || (state_q == ST_WOWN);
   assign dif.idx = (state_q == ST_LOOK) ? next_idx(idx_q, rif.ring_len) : idx_q;
   assign dif.wdata = (state_q == ST_WSTAT) ? wval_q : 32'h0000_0000;
   assign dif.wmask = (state_q == ST_WSTAT) ? STAT_MASK : HOLD_MASK;

   assign rif.ev = ev_q;
   assign rif.cur_idx = idx_q;
   assign rif.state = state_q;

   assign accept = rx_valid_in && rx_ready_out;
   assign d_hold = dif.rdata[HOLD_BIT];
   assign d_start = dif.rdata[START_BIT];
   assign cnt_inc = cnt_q + CNT_ONE;

   // ************
   // next-state logic
   // ************
   always_comb begin
      state_d = state_q;
      post_d = post_q;
      idx_d = idx_q;
      size_d = size_q;
      cnt_d = cnt_q;
      nsize_d = nsize_q;
      first_d = first_q;
      wval_d = wval_q;
      ev_d = '0;
      case (state_q)
         ST_IDLE: begin
            if (rif.en) begin
               state_d = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (dif.done) begin
               if (d_hold && d_start) begin
                  // frame may begin only here [RL10]
                  first_d = 1'b1;
                  size_d = dif.rdata[SIZE_LSB +: CNT_W];
                  cnt_d = CNT_ZERO;
                  state_d = ST_FILL;
               end else if (d_hold) begin
                  // release held non-start descriptor, end written zero [RL11] [RL5]
                  wval_d = stat_word(1'b0, 1'b0, 1'b0, 1'b0, CNT_ZERO);
                  post_d = POST_ADV;
                  ev_d[EV_REL] = 1'b1;
                  state_d = ST_WSTAT;
               end else if (rif.lah) begin
                  // unheld: skip without any write [RL12] [RL6] [RL3]
                  idx_d = next_idx(idx_q, rif.ring_len);
                  state_d = rif.en ? ST_FETCH : ST_IDLE;
               end else begin
                  state_d = rif.en ? ST_FETCH : ST_IDLE;
               end
            end
         end
         ST_FILL: begin
            if (accept) begin
               cnt_d = cnt_inc;
               if (rx_last_in) begin
                  // frame closes here with end or error [RL13] [RL2] [RL5]
                  wval_d = stat_word(first_q, !rx_err_in, rx_err_in, 1'b0, cnt_inc);
                  post_d = POST_ADV;
                  ev_d[EV_DONE] = !rx_err_in;
                  ev_d[EV_ERR] = rx_err_in;
                  state_d = ST_WSTAT;
               end else if (cnt_inc >= size_q) begin
                  state_d = ST_LOOK;
               end
            end else if (cnt_q >= size_q) begin
               state_d = ST_LOOK;
            end
         end
         ST_LOOK: begin
            if (dif.done) begin
               if (d_hold && !d_start) begin
                  // next granted: current ends with end cleared, start set only in the first descriptor [RL1]
                  wval_d = stat_word(first_q, 1'b0, 1'b0, 1'b0, cnt_q);
                  nsize_d = dif.rdata[SIZE_LSB +: CNT_W];
                  post_d = POST_CHAIN;
               end else begin
                  // no buffer to continue into: close with error [RL13]
                  wval_d = stat_word(first_q, 1'b0, 1'b1, 1'b1, cnt_q);
                  post_d = POST_DRAIN;
                  ev_d[EV_BUFF] = 1'b1;
               end
               state_d = ST_WSTAT;
            end
         end
         ST_WSTAT: begin
            if (dif.done) begin
               // status lands before holder flag is cleared [RL14]
               state_d = ST_WOWN;
            end
         end
         ST_WOWN: begin
            if (dif.done) begin
               idx_d = next_idx(idx_q, rif.ring_len);
               case (post_q)
                  POST_CHAIN: begin
                     // frame carries on into the granted descriptor [RL1]
                     first_d = 1'b0;
                     size_d = nsize_q;
                     cnt_d = CNT_ZERO;
                     state_d = ST_FILL;
                  end
                  POST_DRAIN: state_d = ST_DRAIN;
                  default: state_d = rif.en ? ST_FETCH : ST_IDLE;
               endcase
            end
         end
         ST_DRAIN: begin
            if (accept && rx_last_in) begin
               state_d = rif.en ? ST_FETCH : ST_IDLE;
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   // ************
   // engine state
   // ************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         state_q <= ST_IDLE;
         post_q <= POST_ADV;
         idx_q <= '0;
      end else begin
         state_q <= state_d;
         post_q <= post_d;
         idx_q <= idx_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         size_q <= '0;
         cnt_q <= '0;
         nsize_q <= '0;
         first_q <= 1'b0;
         wval_q <= '0;
         ev_q <= '0;
      end else begin
         size_q <= size_d;
         cnt_q <= cnt_d;
         nsize_q <= nsize_d;
         first_q <= first_d;
         wval_q <= wval_d;
         ev_q <= ev_d;
      end
   end

   // ************
   // frame intake and data placement
   // ************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rx_ready_out <= 1'b0;
      end else begin
         rx_ready_out <= ((state_d == ST_FILL) && (cnt_d < size_d)) ||
                         (state_d == ST_DRAIN);
      end
   end

   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         dma_we_out <= 1'b0;
         dma_idx_out <= '0;
         dma_off_out <= '0;
         dma_data_out <= '0;
      end else begin
         dma_we_out <= accept && (state_q == ST_FILL);
         if (accept && (state_q == ST_FILL)) begin
            dma_idx_out <= idx_q;
            dma_off_out <= cnt_q;
            dma_data_out <= rx_data_in;
         end
      end
   end
endmodule

// ---- tb/rlc_rx_lookahead_sva.sv ----
/*
 rlc_rx_lookahead_sva: port checks for the descriptor chain engine.
 assumes a bind to rlc_rx_lookahead, one clock, synchronous reset.
*/
`timescale 1ns/100ps
module rlc_rx_lookahead_sva
   import rlc_pkg::*;
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic rx_valid_in,
   input wire logic [7:0] rx_data_in,
   input wire logic rx_ready_out,
   input wire logic irq_out,
   input wire logic dma_we_out,
   input wire logic [IDX_W-1:0] dma_idx_out,
   input wire logic [CNT_W-1:0] dma_off_out,
   input wire logic [7:0] dma_data_out,
   input wire logic mem_req_out,
   input wire logic mem_we_out,
   input wire logic [IDX_W-1:0] mem_idx_out,
   input wire logic [31:0] mem_wdata_out,
   input wire logic [31:0] mem_wmask_out,
   input wire logic mem_ack_in,
   input wire logic [31:0] mem_rdata_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (sys_rst_in);
   logic [IDX_W-1:0] rd_idx_q, wr_idx_q, pl_idx_q;
   logic rd_held_q, wr_stat_q;
   logic [CNT_W-1:0] pl_off_q;
   // ************
   // last read, last write, last placed byte
   // ************
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         rd_idx_q <= 8'h00;
         rd_held_q <= 1'b0;
      end else if (mem_ack_in && !mem_we_out) begin
         rd_idx_q <= mem_idx_out;
         rd_held_q <= mem_rdata_in[HOLD_BIT];
      end
   end
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         wr_idx_q <= 8'h00;
         wr_stat_q <= 1'b0;
      end else if (mem_ack_in && mem_we_out) begin
         wr_idx_q <= mem_idx_out;
         wr_stat_q <= (mem_wmask_out == STAT_MASK);
      end
   end
   always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
         pl_idx_q <= 8'h00;
         pl_off_q <= 12'h000;
      end else if (dma_we_out) begin
         pl_idx_q <= dma_idx_out;
         pl_off_q <= dma_off_out;
      end
   end
   // ************
   // assertions
   // ************
   stat_first_a: assert property (mem_ack_in && mem_we_out && mem_wmask_out == HOLD_MASK
      |-> wr_stat_q && wr_idx_q == mem_idx_out) else $error("holder cleared before status");
   hold_clear_a: assert property (mem_req_out && mem_we_out && mem_wmask_out == HOLD_MASK
      |-> !mem_wdata_out[HOLD_BIT]) else $error("holder write sets holder");
   start_held_a: assert property (dma_we_out && dma_off_out == 12'h000
      |-> rd_held_q && rd_idx_q == dma_idx_out) else $error("byte placed in unheld slot");
   unheld_wr_a: assert property (mem_req_out && mem_we_out && mem_idx_out == rd_idx_q
      |-> rd_held_q) else $error("write to unheld descriptor");
   byte_cause_a: assert property (dma_we_out |-> $past(rx_valid_in && rx_ready_out)
      && dma_data_out == $past(rx_data_in)) else $error("placed byte without cause");
   off_step_a: assert property (dma_we_out && dma_off_out != 12'h000
      |-> dma_idx_out == pl_idx_q && dma_off_out == pl_off_q + 12'h001) else $error("offset jump");
   req_hold_a: assert property (mem_req_out && !mem_ack_in |=> mem_req_out
      && $stable(mem_idx_out) && $stable(mem_wmask_out) && $stable(mem_wdata_out))
      else $error("request changed before ack");
   ack_gap_a: assert property (mem_ack_in |=> !mem_req_out) else $error("request after ack");
   cover property (mem_ack_in && mem_we_out && mem_wmask_out == HOLD_MASK);
   cover property (dma_we_out && dma_off_out == 12'h000 && $past(dma_we_out));
   cover property ($rose(irq_out));
endmodule

bind rlc_rx_lookahead rlc_rx_lookahead_sva chk_i (.*);

// ---- tb/rlc_mem_model.sv ----
/*
 rlc_mem_model: descriptor ring memory on the engine's port.
 assumes one held request at a time; slow_in sets idle cycles before ack.
*/
`timescale 1ns/100ps
module rlc_mem_model
(
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic req_in,
   input wire logic we_in,
   input wire logic [7:0] idx_in,
   input wire logic [31:0] wdata_in,
   input wire logic [31:0] wmask_in,
   input wire logic [3:0] slow_in,
   output logic ack_out,
   output logic [31:0] rdata_out
);
   logic [31:0] mem [0:255];
   int wr_cnt [0:255] = '{default: 0};
   logic [3:0] wait_q;
   // ************
   // answer; read bus churns when not answering
   // ************
   always @(posedge clk_in) begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      if (sys_rst_in) begin
         wait_q <= 4'h0;
         rdata_out <= 32'h5a5a_a5a5;
      end else if (req_in && !ack_out && wait_q < slow_in) begin
         wait_q <= wait_q + 4'h1;
      end else if (req_in && !ack_out) begin
         wait_q <= 4'h0;
         ack_out <= 1'b1;
         if (we_in) begin
            mem[idx_in] <= (mem[idx_in] & ~wmask_in) | (wdata_in & wmask_in);
            wr_cnt[idx_in] <= wr_cnt[idx_in] + 1;
         end else begin
            rdata_out <= mem[idx_in];
         end
      end
   end
endmodule

// ---- tb/rlc_rx_lookahead_test.sv ----
/*
 rlc_rx_lookahead_test: self-checking bench for the descriptor chain engine.
 assumes rlc_mem_model as descriptor memory and the bound checker.
*/
`timescale 1ns/100ps
module rlc_rx_lookahead_test
   import rlc_pkg::*;
;
   logic clk_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0, rd_d = 1'b0;
   logic rx_valid_in = 1'b0, rx_last_in = 1'b0, rx_err_in = 1'b0;
   logic [7:0] reg_addr_in = 8'h00, rx_data_in = 8'h00, dma_data_out;
   logic [31:0] reg_wdata_in = 32'h0000_0000, reg_rdata_out, mem_rdata_in;
   logic [31:0] mem_wdata_out, mem_wmask_out, lfsr_q = 32'h6b8d7d49;
   logic irq_out, rx_ready_out, dma_we_out, mem_req_out, mem_we_out, mem_ack_in;
   logic [IDX_W-1:0] dma_idx_out, mem_idx_out;
   logic [CNT_W-1:0] dma_off_out;
   logic [3:0] slow_q = 4'h0;
   logic [27:0] dq[$];
   logic [31:0] rq[$];
   int err_total = 0, cmp_count = 0, n5;
   rlc_rx_lookahead uut (.*);
   rlc_mem_model mem_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .req_in(mem_req_out),
      .we_in(mem_we_out), .idx_in(mem_idx_out), .wdata_in(mem_wdata_out),
      .wmask_in(mem_wmask_out), .slow_in(slow_q), .ack_out(mem_ack_in), .rdata_out(mem_rdata_in));
   always #4 clk_in = ~clk_in;
   // ************
   // helpers
   // ************
   function automatic logic [31:0] dw(input int h, s, e, c, sz);
      dw = {h[0], s[0], e[0], 5'h00, c[11:0], sz[11:0]};
   endfunction
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp_dma(input logic [27:0] got, input logic [27:0] exp);
      cmp_word({4'h0, got}, {4'h0, exp});
   endtask
   task automatic chk(input int i, input logic [31:0] e);
      cmp_word(mem_i.mem[i] & 32'he0ff_f000, e);
   endtask
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge clk_in);
      reg_wr_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
      rq.push_back(e);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge clk_in);
      reg_rd_in <= 1'b0;
      @(posedge clk_in);
   endtask
   task automatic send_frame(input int n, i0, s0, s1, keep, input logic bad);
      int k;
      int o;
      for (int i = 0; i < n; i++) begin
         lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
         k = (i < s0) ? 0 : (i < s0 + s1) ? 1 : 2;
         o = i - (k > 0 ? s0 : 0) - (k > 1 ? s1 : 0);
         if (i < keep) dq.push_back({8'(i0 + k), o[11:0], lfsr_q[7:0]});
         rx_valid_in <= 1'b1;
         rx_data_in <= lfsr_q[7:0];
         rx_last_in <= (i == n - 1);
         rx_err_in <= bad && (i == n - 1);
         @(posedge clk_in);
         while (rx_ready_out !== 1'b1) @(posedge clk_in);
      end
      rx_valid_in <= 1'b0;
      rx_last_in <= 1'b0;
   endtask
   task automatic wait_free(input int i);
      int n;
      n = 0;
      while ((mem_i.mem[i][HOLD_BIT] !== 1'b0 || dq.size() > 0) && n < 2000) begin
         @(posedge clk_in);
         n++;
      end
      if (n == 2000) err_total++;
      @(posedge clk_in);
   endtask
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // ************
   // result watcher
   // ************
   always @(posedge clk_in) begin
      if (rd_d === 1'b1) cmp_word(reg_rdata_out, rq.pop_front());
      rd_d = reg_rd_in;
      if (dma_we_out === 1'b1) cmp_dma({dma_idx_out, dma_off_out, dma_data_out}, dq.size() ? dq.pop_front() : 28'hxxx_xxxx);
   end
   initial begin
      repeat (30000) @(posedge clk_in);
      err_total++;
      stop_test();
   end
   // ************
   // scenarios
   // ************
   initial begin
      for (int i = 0; i < 6; i += 3) begin
         mem_i.mem[i] = dw(1, 1, 0, 0, 8);
         mem_i.mem[i + 1] = dw(1, 0, 0, 0, 4);
         mem_i.mem[i + 2] = dw(i / 3, 0, 1, 0, 4);
      end
      repeat (10) @(posedge clk_in);
      sys_rst_in <= 1'b0;
      @(posedge clk_in);
      reg_rd(REG_RING, {24'h00_0000, RING_RST});
      reg_rd(REG_CTRL, 32'h0000_0000);
      reg_wr(REG_RING, 32'h0000_0006);
      reg_wr(REG_IEN, 32'h0000_0004);
      reg_wr(REG_CTRL, 32'h0000_0003);
      send_frame(5, 0, 8, 4, 5, 1'b0);
      wait_free(1);
      chk(0, dw(0, 1, 1, 5, 0));
      chk(1, dw(0, 0, 0, 0, 0));
      cmp_word(32'(mem_i.wr_cnt[2]), 32'h0000_0000);
      $display("short frame done");
      slow_q <= 4'h5;
      send_frame(14, 3, 8, 4, 14, 1'b0);
      wait_free(5);
      chk(3, dw(0, 1, 0, 8, 0));
      chk(4, dw(0, 0, 0, 4, 0));
      chk(5, dw(0, 0, 1, 2, 0));
      cmp_word({31'h0000_0000, irq_out}, 32'h0000_0000);
      $display("three buffer frame done");
      slow_q <= 4'h0;
      mem_i.mem[1] = dw(1, 0, 0, 0, 4);
      mem_i.mem[0] = dw(1, 1, 0, 0, 8);
      send_frame(10, 0, 8, 4, 10, 1'b0);
      wait_free(1);
      chk(0, dw(0, 1, 0, 8, 0));
      chk(1, dw(0, 0, 1, 2, 0));
      cmp_word(mem_i.mem[2], dw(0, 0, 1, 0, 4));
      $display("early end frame done");
      n5 = mem_i.wr_cnt[5];
      slow_q <= 4'h3;
      mem_i.mem[4] = dw(1, 0, 0, 0, 4);
      mem_i.mem[3] = dw(1, 1, 0, 0, 8);
      send_frame(16, 3, 8, 4, 12, 1'b1);
      wait_free(4);
      chk(3, dw(0, 1, 0, 8, 0));
      cmp_word(mem_i.mem[4] & 32'h9800_0000, 32'h1800_0000);
      cmp_word(32'(mem_i.wr_cnt[5] - n5), 32'h0000_0000);
      reg_rd(REG_STAT, 32'h0000_000d);
      cmp_word({31'h0000_0000, irq_out}, 32'h0000_0001);
      reg_wr(REG_ICLR, 32'h0000_0004);
      reg_wr(REG_STAT, 32'h0000_0000);
      reg_rd(REG_STAT, 32'h0000_0009);
      reg_rd(REG_ICLR, 32'h0000_0000);
      reg_rd(8'h20, 32'h0000_0000);
      cmp_word({31'h0000_0000, irq_out}, 32'h0000_0000);
      $display("overflow frame done");
      stop_test();
   end
endmodule
